// *** hw/pbbp_defs.svh ***
// Constants for the parallel bit-bang port
`ifndef PBBP_DEFS_SVH
`define PBBP_DEFS_SVH
`define PBBP_MODE_RESET  8'h00
`define PBBP_MODE_ASYNC  8'h01
`define PBBP_MODE_SYNC   8'h04
`define PBBP_WIDTH       8
`define PBBP_BAUD_DIV    16'h0010
`define PBBP_BAUD_ONE    16'h0001
`define PBBP_SETUP_CYC   1
`endif

// *** hw/pbbp_pkg.sv ***
// Types for the parallel bit-bang port
package pbbp_pkg;
  typedef enum logic [1:0] {
    PBBP_ST_IDLE,
    PBBP_ST_SAMPLE,
    PBBP_ST_DRIVE,
    PBBP_ST_SETUP
  } pbbp_sync_st_t;
endpackage

// *** hw/pbbp_port.sv ***
// Bit-bang parallel I/O engine for one bridge channel
//
// Summary of operation
// [RL1] Channel runs synchronous or asynchronous bit-bang
// [RL2] Async mode clocks host bytes onto outputs
// [RL3] Each pin direction set individually
// [RL4] Baud generator paces async output bytes
// [RL5] Async outputs change on byte plus tick
// [RL6] Sync outputs update only per host byte
// [RL7] Sync sample returned only per written byte
// [RL8] Sync waits for transmit FIFO room
// [RL9] Pins sampled before applying, one byte lag
// [RL10] Host selects async with mode code one
// [RL11] Host selects sync with mode code four
// [RL12] No strobes driven in bit-bang modes
// [RL13] Capture pins first, then change outputs
// [RL14] One setup cycle after applying new data
// [RL15] Mode code zero returns channel to reset
// [RL16] Inputs undriven; bit n maps pin n
`timescale 1ns/1ns
`include "pbbp_defs.svh"
module pbbp_port #(
  parameter int          WIDTH    = `PBBP_WIDTH,
  parameter logic [15:0] BAUD_DIV = `PBBP_BAUD_DIV
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [7:0]       mode_code,
  input  wire logic [WIDTH-1:0] pin_dir,
  input  wire logic [WIDTH-1:0] rx_data,
  input  wire logic             rx_valid,
  output logic                  rx_ready,
  output logic      [WIDTH-1:0] tx_data,
  output logic                  tx_valid,
  input  wire logic             tx_ready,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic                  write_phase_strobe_n,
  output logic                  read_phase_strobe_n
);

  //////////////////////////////////////////////////////////////////////
  // Mode decode and pin synchroniser

  logic             is_async;           // Asynchronous bit-bang selected
  logic             is_sync;            // Synchronous bit-bang selected
  logic [WIDTH-1:0] pin_meta_ff;        // First synchroniser stage
  logic [WIDTH-1:0] pin_sync_ff;        // Second synchroniser stage
  logic [15:0]      baud_cnt_ff;        // Baud divider count
  logic             baud_tick;          // One-cycle baud enable
  logic             async_take;         // Async byte taken this cycle
  logic             sync_take;          // Sync byte taken this cycle
  pbbp_pkg::pbbp_sync_st_t st_ff;       // Sync sequencer state
  pbbp_pkg::pbbp_sync_st_t nxt_st;      // Next sequencer state
  logic [WIDTH-1:0] hold_ff;            // Byte waiting to be driven

  // Codes one and four pick the variant; others leave it idle
  assign is_async = (mode_code == `PBBP_MODE_ASYNC); // see [RL1] [RL10]
  assign is_sync  = (mode_code == `PBBP_MODE_SYNC);  // see [RL1] [RL11]

  // Two-stage synchroniser on the external pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Baud rate generator

  // Free-running divider, cleared outside async mode
  always_ff @(posedge mclk) begin
    if (reset || !is_async) begin
      baud_cnt_ff <= 16'h0000;
    end else if (baud_tick) begin
      baud_cnt_ff <= 16'h0000;
    end else begin
      baud_cnt_ff <= baud_cnt_ff + `PBBP_BAUD_ONE;
    end
  end
  assign baud_tick = is_async &&
                     (baud_cnt_ff == BAUD_DIV - `PBBP_BAUD_ONE); // see [RL4]

  //////////////////////////////////////////////////////////////////////
  // Receive handshake

  // Async takes a byte only on a tick; sync only when idle
  assign async_take = baud_tick && rx_valid;                 // see [RL5]
  assign sync_take  = is_sync && (st_ff == pbbp_pkg::PBBP_ST_IDLE) &&
                      rx_valid && !tx_valid;                 // see [RL8]
  assign rx_ready   = (baud_tick ||
                      (is_sync && (st_ff == pbbp_pkg::PBBP_ST_IDLE) &&
                       !tx_valid));

  //////////////////////////////////////////////////////////////////////
  // Synchronous sequencer

  // Idle, sample pins, drive byte, one setup cycle
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      pbbp_pkg::PBBP_ST_IDLE: begin
        if (sync_take) begin
          nxt_st = pbbp_pkg::PBBP_ST_SAMPLE;
        end
      end
      pbbp_pkg::PBBP_ST_SAMPLE: begin
        nxt_st = pbbp_pkg::PBBP_ST_DRIVE;                 // see [RL13]
      end
      pbbp_pkg::PBBP_ST_DRIVE: begin
        nxt_st = pbbp_pkg::PBBP_ST_SETUP;                 // see [RL14]
      end
      pbbp_pkg::PBBP_ST_SETUP: begin
        nxt_st = pbbp_pkg::PBBP_ST_IDLE;
      end
      default: begin
        nxt_st = pbbp_pkg::PBBP_ST_IDLE;
      end
    endcase
  end

  // State register; mode change away from sync returns it to idle
  always_ff @(posedge mclk) begin
    if (reset || !is_sync) begin                          // see [RL15]
      st_ff <= pbbp_pkg::PBBP_ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Latch the byte taken from the receive stream
  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_ff <= '0;
    end else if (sync_take) begin
      hold_ff <= rx_data;                                 // see [RL6]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Return sample toward host

  // Sample taken before the new byte drives, one byte behind
  always_ff @(posedge mclk) begin
    if (reset || !is_sync) begin
      tx_valid <= 1'b0;
      tx_data  <= '0;
    end else if (st_ff == pbbp_pkg::PBBP_ST_SAMPLE) begin
      tx_valid <= 1'b1;                                   // see [RL7]
      tx_data  <= pin_sync_ff;                            // see [RL9] [RL16]
    end else if (tx_valid && tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Output pins

  // Output latch: holds last byte until a new one is applied
  always_ff @(posedge mclk) begin
    if (reset || !(is_async || is_sync)) begin            // see [RL15]
      pin_out <= '0;
    end else if (async_take) begin
      pin_out <= rx_data;                                 // see [RL2] [RL5]
    end else if (st_ff == pbbp_pkg::PBBP_ST_DRIVE) begin
      pin_out <= hold_ff;                                 // see [RL6] [RL13]
    end
  end

  // Per-pin enables; inputs stay undriven and reset idles all
  always_ff @(posedge mclk) begin
    if (reset || !(is_async || is_sync)) begin
      pin_oe <= '0;
    end else begin
      pin_oe <= pin_dir;                                  // see [RL3] [RL16]
    end
  end

  // Strobes held inactive in bit-bang operation
  assign write_phase_strobe_n = 1'b1;                     // see [RL12]
  assign read_phase_strobe_n  = 1'b1;                     // see [RL12]

  //////////////////////////////////////////////////////////////////////
  // Assertions

  property p_sync_seq;
    @(posedge mclk) disable iff (reset || !is_sync)
      sync_take |=> (st_ff == pbbp_pkg::PBBP_ST_SAMPLE) ##1
      (st_ff == pbbp_pkg::PBBP_ST_DRIVE) ##1
      (st_ff == pbbp_pkg::PBBP_ST_SETUP);
  endproperty
  a_sync_seq: assert property (p_sync_seq) // see [RL13] [RL14]
    else $error("sync sequence out of order");

  property p_sample_first;
    @(posedge mclk) disable iff (reset || !is_sync)
      (st_ff == pbbp_pkg::PBBP_ST_SAMPLE) |=>
      tx_valid && (tx_data == $past(pin_sync_ff));
  endproperty
  a_sample_first: assert property (p_sample_first) // see [RL9]
    else $error("sample not captured before drive");

  property p_sync_drive;
    @(posedge mclk) disable iff (reset || !is_sync)
      sync_take |-> ##3 (pin_out == $past(rx_data, 3));
  endproperty
  a_sync_drive: assert property (p_sync_drive) // see [RL6]
    else $error("sync byte not driven");

  property p_tx_room;
    @(posedge mclk) disable iff (reset)
      tx_valid |-> !sync_take;
  endproperty
  a_tx_room: assert property (p_tx_room) // see [RL8]
    else $error("byte taken without transmit room");

  property p_tx_cause;
    @(posedge mclk) disable iff (reset || !is_sync)
      $rose(tx_valid) |-> $past(st_ff) == pbbp_pkg::PBBP_ST_SAMPLE;
  endproperty
  a_tx_cause: assert property (p_tx_cause) // see [RL7]
    else $error("sample sent without written byte");

  property p_async_hold;
    @(posedge mclk) disable iff (reset || !is_async)
      !$past(async_take) && $past(is_async) |-> $stable(pin_out);
  endproperty
  a_async_hold: assert property (p_async_hold) // see [RL5]
    else $error("async output changed without tick");

  property p_async_take;
    @(posedge mclk) disable iff (reset)
      async_take |=> (pin_out == $past(rx_data));
  endproperty
  a_async_take: assert property (p_async_take) // see [RL2] [RL4]
    else $error("async byte not applied");

  property p_strobes;
    @(posedge mclk) disable iff (reset)
      write_phase_strobe_n && read_phase_strobe_n;
  endproperty
  a_strobes: assert property (p_strobes) // see [RL12]
    else $error("strobe driven in bit-bang mode");

  property p_oe_dir;
    @(posedge mclk) disable iff (reset)
      $past(is_async || is_sync) && !$past(reset) |->
      pin_oe == $past(pin_dir);
  endproperty
  a_oe_dir: assert property (p_oe_dir) // see [RL3] [RL16]
    else $error("pin enable differs from direction");

  c_sync_cycle: cover property (@(posedge mclk)
    sync_take ##3 (st_ff == pbbp_pkg::PBBP_ST_SETUP));
  c_async_byte: cover property (@(posedge mclk) async_take);
  c_tx_stall:   cover property (@(posedge mclk)
    is_sync && tx_valid && !tx_ready && rx_valid);

endmodule // pbbp_port

// *** verif/pbbp_pin_model.sv ***
// Outside logic that shares the parallel pins with the port
`timescale 1ns/1ns
module pbbp_pin_model (
  input  wire logic [7:0] pin_out, // Values the port drives
  input  wire logic [7:0] pin_oe,  // Port drive enables
  input  wire logic [7:0] ext_val, // Levels set by outside logic
  output logic      [7:0] pin_in   // Resolved pin levels
);
  // Driven pins follow the port, the others follow outside logic
  assign pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule // pbbp_pin_model

// *** verif/testbench.sv ***
// Self-checking bench for the parallel bit-bang port
`timescale 1ns/1ns
`include "pbbp_defs.svh"
module testbench;
  logic       mclk;      // System clock
  logic       reset;     // Synchronous reset
  logic [7:0] mode_code; // Mode selection
  logic [7:0] pin_dir;   // Pin directions
  logic [7:0] rx_data;   // Host byte
  logic       rx_valid;  // Host byte present
  logic       rx_ready;  // Byte taken
  logic [7:0] tx_data;   // Sample to host
  logic       tx_valid;  // Sample present
  logic       tx_ready;  // Host accepts sample
  logic [7:0] pin_in;    // Resolved pins
  logic [7:0] pin_out;   // Driven values
  logic [7:0] pin_oe;    // Drive enables
  logic [7:0] ext_val;   // Outside logic levels
  logic       wr_stb_n;  // Write strobe
  logic       rd_stb_n;  // Read strobe
  int         err_count; // Mismatches
  int         n_tests;   // Comparisons
  logic [7:0] d;         // Last returned sample
  //////////////////////////////////////////////////////////////////////////
  pbbp_port #(.WIDTH(8), .BAUD_DIV(16'h0004)) DUT (
    .mclk(mclk), .reset(reset), .mode_code(mode_code),
    .pin_dir(pin_dir), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .write_phase_strobe_n(wr_stb_n),
    .read_phase_strobe_n(rd_stb_n));
  pbbp_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_val(ext_val), .pin_in(pin_in));
  //////////////////////////////////////////////////////////////////////////
  // Compare one value
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Offer a byte until taken; called at a falling edge
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    rx_data = b;
    rx_valid = 1'b1;
    while (rx_ready !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 60) begin
      err_count++;
      $display("MISMATCH rx_ready exp 1 got 0");
    end
    @(negedge mclk);
    rx_valid = 1'b0;
  endtask
  // Wait for a sample and accept it
  task automatic get_tx();
    int n;
    n = 0;
    while (tx_valid !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 60) begin
      err_count++;
      $display("MISMATCH tx_valid exp 1 got 0");
    end
    d = tx_data;
    tx_ready = 1'b1;
    @(negedge mclk);
    tx_ready = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("oe", 8'h00, pin_oe);
    chk("out", 8'h00, pin_out);
    chk("txv", 8'h00, {7'h00, tx_valid});
    chk("stb", 8'h03, {6'h00, wr_stb_n, rd_stb_n});
    $display("end reset");
  endtask
  // Samples lag the written bytes by one
  task automatic t_sync();
    logic [7:0] b [3] = '{8'h55, 8'hAA, 8'hAA};
    logic [7:0] e [3] = '{8'h00, 8'h55, 8'hAA};
    mode_code = `PBBP_MODE_SYNC;
    pin_dir = 8'hFF;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 3; i++) begin
      send(b[i]);
      repeat (4) @(negedge mclk);
      chk("rdy", 8'h00, {7'h00, rx_ready});
      chk("out", b[i], pin_out);
      get_tx();
      chk("smp", e[i], d);
    end
    repeat (20) @(negedge mclk);
    chk("txv", 8'h00, {7'h00, tx_valid});
    chk("stb", 8'h03, {6'h00, wr_stb_n, rd_stb_n});
    $display("end sync");
  endtask
  // Mixed directions: upper pins are inputs
  task automatic t_dir();
    ext_val = 8'hA5;
    pin_dir = 8'h0F;
    send(8'h3C);
    get_tx();
    chk("oe", 8'h0F, pin_oe);
    send(8'h00);
    get_tx();
    chk("smp", 8'hAC, d);
    $display("end dir");
  endtask
  // Bytes paced by the baud tick and held without new data
  task automatic t_async();
    int k;
    k = 0;
    mode_code = `PBBP_MODE_ASYNC;
    pin_dir = 8'hFF;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 16; i++) begin
      k += (rx_ready === 1'b1);
      @(negedge mclk);
    end
    chk("ticks", 8'h04, k[7:0]);
    send(8'h5A);
    @(negedge mclk);
    chk("out", 8'h5A, pin_out);
    repeat (12) @(negedge mclk);
    chk("hold", 8'h5A, pin_out);
    send(8'h81);
    @(negedge mclk);
    chk("out", 8'h81, pin_out);
    chk("txv", 8'h00, {7'h00, tx_valid});
    chk("stb", 8'h03, {6'h00, wr_stb_n, rd_stb_n});
    $display("end async");
  endtask
  // Mode code zero returns the channel to rest
  task automatic t_idle();
    mode_code = `PBBP_MODE_RESET;
    repeat (2) @(negedge mclk);
    chk("oe", 8'h00, pin_oe);
    chk("out", 8'h00, pin_out);
    $display("end idle");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    mode_code = `PBBP_MODE_RESET;
    pin_dir = 8'h00;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    ext_val = 8'hFF;
    err_count = 0;
    n_tests = 0;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    t_reset();
    t_sync();
    t_dir();
    t_async();
    t_idle();
    give_verdict();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    give_verdict();
  end
endmodule // testbench
